//--- logic/plgc_cell.v
// plgc_cell.v: programmable logic cell pair with bus interconnect and Wishbone registers
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "plgc_map.vh"

module plgc_cell (
    // clock and resets
    input  wire        clk_in,
    input  wire        srst_in,
    input  wire        sys_rst_n_in,
    input  wire        cfg_reset_in,
    // wishbone slave
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [7:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output wire [31:0] wb_dat_out,
    output wire        wb_ack_out,
    // cell inputs from neighbouring fabric logic
    input  wire [3:0]  in_a_in,
    input  wire [3:0]  in_b_in,
    input  wire        in_e_in,
    input  wire        ff_en_in,
    input  wire [5:0]  gbuf_in,
    input  wire        carry_in,
    // cell outputs
    output wire        cell_a_out,
    output wire        cell_b_out,
    output wire        shift_out,
    output wire        carry_out,
    // fabric system bus distribution
    output wire [31:0] wdata_route_out,
    input  wire [31:0] rd_or_in,
    input  wire        rd_sel_in,
    output wire [31:0] rd_or_out,
    input  wire [3:0]  chain_in,
    input  wire        chain_en_in,
    output wire [3:0]  chain_out
);

    // shadow registers written by software
    reg  [31:0] ctrl_reg;
    reg  [31:0] table_reg;
    reg  [31:0] gbsel_reg;
    // active static configuration
    reg  [31:0] act_ctrl_reg;
    reg  [31:0] act_gbsel_reg;
    // cell storage
    reg  [15:0] lut_a_reg;
    reg  [15:0] lut_b_reg;
    reg  [7:0]  shift_reg;
    reg         ff_reg;
    reg         clk_prev_reg;
    reg         cfg_req_reg;
    // bus side
    reg         ack_reg;
    reg  [31:0] rdat_reg;
    reg  [31:0] wdata_reg;
    reg  [31:0] rd_or_reg;

    wire [2:0]  mode;
    wire [1:0]  csrc;
    wire [1:0]  aop;
    wire        bus_req;
    wire        bus_wr;
    wire [5:0]  word_idx;
    wire        cfg_pulse;
    wire [2:0]  local_gbuf;
    wire        clk_cur;
    wire        tick;

    // combine two bits under a configured operation
    function comb_op;
        input [1:0] op;
        input       a;
        input       b;
        begin
            case (op)
                `PLGC_OP_AND: comb_op = a & b;
                `PLGC_OP_OR:  comb_op = a | b;
                `PLGC_OP_XOR: comb_op = a ^ b;
                default:      comb_op = a;
            endcase
        end
    endfunction

    // byte-lane merge for wishbone writes
    function [31:0] lane_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  sel;
        integer      i;
        begin
            lane_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    assign mode     = act_ctrl_reg[`PLGC_F_MODE];
    assign csrc     = act_ctrl_reg[`PLGC_F_CSRC];
    assign aop      = act_ctrl_reg[`PLGC_F_AOP];
    assign word_idx = wb_adr_in[7:2];

    // request seen, ack one cycle later; writes land at the ack edge
    assign bus_req = wb_cyc_in & wb_stb_in & ~ack_reg;
    assign bus_wr  = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg;

    // three of six global buffers picked into the bank
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gb_pick
            wire [2:0] gsel;
            assign gsel = act_gbsel_reg[g*`PLGC_F_GB_W +: `PLGC_F_GB_W];
            assign local_gbuf[g] = (gsel < 3'h6) ? gbuf_in[gsel] : 1'b0;
        end
    endgenerate

    // bus clock ticks every cycle; buffer lines act on the chosen edge
    assign clk_cur = (csrc == `PLGC_CSRC_BUS) ? 1'b1 : local_gbuf[csrc - 2'h1];
    assign tick = (csrc == `PLGC_CSRC_BUS) ? 1'b1 :
                  act_ctrl_reg[`PLGC_F_FALL] ? (clk_prev_reg & ~clk_cur)
                                              : (~clk_prev_reg & clk_cur);

    // configuration reset from the pin or a software trigger
    assign cfg_pulse = cfg_reset_in | cfg_req_reg;

    // combinational datapath
    wire tbl_a;
    wire tbl_b4;
    wire tbl_b5;
    wire five_input_table_val;
    wire wide_val;
    wire ar_x;
    wire ar_y;
    wire ar_m;
    wire ar_ld;
    wire ram_di;
    wire ram_we;
    reg  op_p;
    reg  op_q;
    wire sum;
    wire co;
    wire arith_val;
    reg  f_main;
    wire f_cas;
    wire is_logic;

    assign tbl_a  = lut_a_reg[in_a_in];
    assign tbl_b4 = lut_b_reg[in_b_in];
    assign tbl_b5 = lut_b_reg[in_a_in];
    // fifth input picks between the two tables
    assign five_input_table_val = in_e_in ? tbl_b5 : tbl_a;
    // restricted set: two tables combined, steered by the ninth input
    assign wide_val = in_e_in ? comb_op(act_ctrl_reg[`PLGC_F_WOP], tbl_a, tbl_b4) : tbl_a;

    assign ar_x   = in_a_in[0];
    assign ar_y   = in_a_in[1];
    assign ar_m   = in_a_in[2];
    assign ar_ld  = in_a_in[3];
    assign ram_di = in_b_in[0];
    assign ram_we = in_b_in[1];

    // one-bit add, subtract, add/subtract and multiply step
    always @* begin
        op_p = ar_x;
        op_q = ar_y;
        case (aop)
            `PLGC_A_ADD: begin
                op_q = ar_y;
            end
            `PLGC_A_SUB: begin
                // first carry of a subtract chain must be one
                op_q = ~ar_y;
            end
            `PLGC_A_ADDSUB: begin
                op_q = ar_y ^ ar_m;
            end
            `PLGC_A_MULT: begin
                op_p = ar_y;
                op_q = ar_x & ar_m;
            end
            default: begin
                op_q = ar_y;
            end
        endcase
    end

    assign sum       = op_p ^ op_q ^ carry_in;
    assign co        = (op_p & op_q) | (carry_in & (op_p ^ op_q));
    assign arith_val = ar_ld ? ram_di : sum;

    // memory reads are address-only, no clock involved
    always @* begin
        case (mode)
            `PLGC_M_FOUR_INPUT_TABLE:  f_main = tbl_a;
            `PLGC_M_FIVE_INPUT_TABLE:  f_main = five_input_table_val;
            `PLGC_M_WIDE:  f_main = wide_val;
            `PLGC_M_ARITH: f_main = arith_val;
            `PLGC_M_RAM16: f_main = tbl_a;
            `PLGC_M_RAM32: f_main = five_input_table_val;
            `PLGC_M_SHIFT: f_main = shift_reg[7];
            default:       f_main = tbl_a;
        endcase
    end

    assign is_logic = (mode == `PLGC_M_FOUR_INPUT_TABLE) | (mode == `PLGC_M_FIVE_INPUT_TABLE) |
                      (mode == `PLGC_M_WIDE);
    // cascade folds the neighbour's result into wide logic
    assign f_cas = is_logic ? comb_op(act_ctrl_reg[`PLGC_F_COP], f_main, carry_in) : f_main;

    assign carry_out  = (mode == `PLGC_M_ARITH) ? co : f_cas;
    // flip-flop used alone, bypassed or after the function
    assign cell_a_out = act_ctrl_reg[`PLGC_F_USEFF] ? ff_reg : f_cas;
    // second cell stands alone only in four-input mode
    assign cell_b_out = (mode == `PLGC_M_FOUR_INPUT_TABLE) ? tbl_b4 : f_cas;
    assign shift_out  = shift_reg[7];

    // cell state: system reset does not touch any of it
    always @(posedge clk_in) begin
        if (srst_in) begin
            act_ctrl_reg  <= `PLGC_CTRL_RST;
            act_gbsel_reg <= `PLGC_GBSEL_RST;
            lut_a_reg     <= `PLGC_LUT_RST;
            lut_b_reg     <= `PLGC_LUT_RST;
            shift_reg     <= 8'h00;
            ff_reg        <= 1'b0;
            clk_prev_reg  <= 1'b0;
        end else if (cfg_pulse) begin
            // static selections change only here
            act_ctrl_reg  <= ctrl_reg;
            act_gbsel_reg <= gbsel_reg;
            // preset memories and flip-flop
            lut_a_reg     <= table_reg[15:0];
            lut_b_reg     <= table_reg[31:16];
            shift_reg     <= gbsel_reg[`PLGC_F_SRINIT];
            ff_reg        <= ctrl_reg[`PLGC_F_FFINIT];
            clk_prev_reg  <= 1'b0;
        end else begin
            clk_prev_reg <= clk_cur;
            if (tick) begin
                if (ff_en_in) begin
                    ff_reg <= f_cas;
                end
                case (mode)
                    `PLGC_M_RAM16: begin
                        if (ram_we) begin
                            lut_a_reg[in_a_in] <= ram_di;
                        end
                    end
                    `PLGC_M_RAM32: begin
                        if (ram_we & in_e_in) begin
                            lut_b_reg[in_a_in] <= ram_di;
                        end else if (ram_we) begin
                            lut_a_reg[in_a_in] <= ram_di;
                        end
                    end
                    `PLGC_M_SHIFT: begin
                        shift_reg <= {shift_reg[6:0], ram_di};
                    end
                    default: begin
                        shift_reg <= shift_reg;
                    end
                endcase
            end
        end
    end

    // wishbone ack; system reset only drops a pending answer
    always @(posedge clk_in) begin
        if (srst_in | ~sys_rst_n_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    // read data captured with the request, held while ack is high
    always @(posedge clk_in) begin
        if (srst_in) begin
            rdat_reg <= 32'h0000_0000;
        end else if (bus_req) begin
            case (word_idx)
                `PLGC_OFF_CTRL:   rdat_reg <= {1'b0, ctrl_reg[30:0]};
                `PLGC_OFF_TABLE:  rdat_reg <= table_reg;
                `PLGC_OFF_GBSEL:  rdat_reg <= gbsel_reg;
                `PLGC_OFF_STATUS: rdat_reg <= {16'h0000, shift_reg, 1'b0, carry_out,
                                               ff_reg, cell_b_out, cell_a_out, mode};
                `PLGC_OFF_STORE:  rdat_reg <= {lut_b_reg, lut_a_reg};
                default:          rdat_reg <= 32'h0000_0000;
            endcase
        end
    end

    // shadow register writes; unmapped and read-only words ignore writes
    always @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_reg    <= `PLGC_CTRL_RST;
            table_reg   <= `PLGC_TABLE_RST;
            gbsel_reg   <= `PLGC_GBSEL_RST;
            cfg_req_reg <= 1'b0;
        end else begin
            cfg_req_reg <= 1'b0;
            if (bus_wr) begin
                case (word_idx)
                    `PLGC_OFF_CTRL: begin
                        ctrl_reg    <= lane_merge(ctrl_reg, wb_dat_in, wb_sel_in) &
                                       32'h7fff_ffff;
                        // trigger bit is self-clearing and never stored
                        cfg_req_reg <= wb_sel_in[3] & wb_dat_in[`PLGC_F_CFGRST];
                    end
                    `PLGC_OFF_TABLE: begin
                        table_reg <= lane_merge(table_reg, wb_dat_in, wb_sel_in);
                    end
                    `PLGC_OFF_GBSEL: begin
                        gbsel_reg <= lane_merge(gbsel_reg, wb_dat_in, wb_sel_in);
                    end
                    default: begin
                        ctrl_reg <= ctrl_reg;
                    end
                endcase
            end
        end
    end

    // every write word is fanned out to the routing matrices
    always @(posedge clk_in) begin
        if (srst_in) begin
            wdata_reg <= 32'h0000_0000;
        end else if (bus_wr) begin
            wdata_reg <= wb_dat_in;
        end
    end

    // OR-chain stage: unselected cells add zeros, costs one cycle per hop
    always @(posedge clk_in) begin
        if (srst_in) begin
            rd_or_reg <= 32'h0000_0000;
        end else begin
            rd_or_reg <= rd_or_in |
                         (rd_sel_in ? {29'h0, shift_reg[7], cell_b_out, cell_a_out}
                                    : 32'h0000_0000);
        end
    end

    // multiplexer chains: unidirectional, so no driver fight can occur
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : mux_chain
            assign chain_out[c] = (chain_en_in & act_ctrl_reg[`PLGC_F_CHAIN_LO + c]) ?
                                  cell_a_out : chain_in[c];
        end
    endgenerate

    assign wb_ack_out      = ack_reg;
    assign wb_dat_out      = ack_reg ? rdat_reg : 32'h0000_0000;
    assign wdata_route_out = wdata_reg;
    assign rd_or_out       = rd_or_reg;

endmodule // plgc_cell

//--- shared/plgc_map.vh
// plgc_map.vh: register map, field positions and encodings of the programmable logic cell
// What this block does
// - cell has flip-flop plus combinational function
// - four-input table gives any four-input function
// - cell pair gives any five-input function
// - cell pair gives some six-to-nine-input functions
// - path selections are static, loaded at configuration
// - carry or cascade link joins adjacent cells
// - arithmetic mode does add, subtract, multiply steps
// - memory mode gives 16x1 and 32x1 RAM
// - RAM writes one data bit only when enabled
// - RAM write edge polarity is configurable
// - RAM write samples data, address, enable at edge
// - RAM read follows address alone, combinationally
// - RAM contents preset from configured initial values
// - only power-on or configuration reset reloads state
// - memory mode offers eight-bit serial shift register
// - bus write data reaches every routing matrix
// - read data gathered by OR-chain, idle drives zero
// - four multiplexer chains emulate shared bidirectional bus
// - bus clock plus three of six global buffers
`ifndef PLGC_MAP_VH
`define PLGC_MAP_VH

// register word offsets, taken from byte address bits 7:2
`define PLGC_OFF_CTRL    6'h00
`define PLGC_OFF_TABLE   6'h01
`define PLGC_OFF_GBSEL   6'h02
`define PLGC_OFF_STATUS  6'h03
`define PLGC_OFF_STORE   6'h04

// reset values
`define PLGC_CTRL_RST    32'h0000_0000
`define PLGC_TABLE_RST   32'h0000_0000
`define PLGC_GBSEL_RST   32'h0000_0000
`define PLGC_LUT_RST     16'h0000

// control fields
`define PLGC_F_MODE      2:0
`define PLGC_F_FALL      3
`define PLGC_F_CSRC      5:4
`define PLGC_F_USEFF     6
`define PLGC_F_WOP       8:7
`define PLGC_F_COP       10:9
`define PLGC_F_AOP       12:11
`define PLGC_F_FFINIT    13
`define PLGC_F_CHAIN_LO  14
`define PLGC_F_CFGRST    31

// global buffer select fields and shift register preset
`define PLGC_F_GB_W      3
`define PLGC_F_SRINIT    23:16

// cell modes
`define PLGC_M_FOUR_INPUT_TABLE      3'h0
`define PLGC_M_FIVE_INPUT_TABLE      3'h1
`define PLGC_M_WIDE      3'h2
`define PLGC_M_ARITH     3'h3
`define PLGC_M_RAM16     3'h4
`define PLGC_M_RAM32     3'h5
`define PLGC_M_SHIFT     3'h6

// combine operations for wide and cascade logic
`define PLGC_OP_AND      2'h0
`define PLGC_OP_OR       2'h1
`define PLGC_OP_XOR      2'h2
`define PLGC_OP_PASS     2'h3

// arithmetic operations
`define PLGC_A_ADD       2'h0
`define PLGC_A_SUB       2'h1
`define PLGC_A_ADDSUB    2'h2
`define PLGC_A_MULT      2'h3

// clock sources: 0 is the bus clock, 1..3 the selected global buffers
`define PLGC_CSRC_BUS    2'h0

`endif

//--- tb/plgc_cell_asserts.sv
// plgc_cell_asserts.sv: port-level assertions for the logic cell
`timescale 1ns/10ps
module plgc_cell_chk (
    // clock and resets
    input wire        clk_in,
    input wire        srst_in,
    input wire        sys_rst_n_in,
    // wishbone
    input wire        wb_cyc_in,
    input wire        wb_stb_in,
    input wire        wb_we_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire        wb_ack_out,
    // fabric bus and cell
    input wire [31:0] rd_or_in,
    input wire        rd_sel_in,
    input wire [31:0] rd_or_out,
    input wire        cell_a_out,
    input wire        cell_b_out,
    input wire        shift_out,
    input wire [31:0] wdata_route_out,
    input wire [3:0]  chain_in,
    input wire        chain_en_in,
    input wire [3:0]  chain_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wire req = wb_cyc_in && wb_stb_in;

    a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held past one cycle");
    a_ack_has_req: assert property ($rose(wb_ack_out) |-> $past(req))
        else $error("ack without request");
    a_req_answered: assert property (req && !wb_ack_out && sys_rst_n_in
        |=> wb_ack_out || !sys_rst_n_in)
        else $error("request not answered next cycle");
    a_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data not zero while idle");
    a_route_write: assert property (wb_ack_out && wb_we_in |=>
        wdata_route_out == $past(wb_dat_in))
        else $error("write word not routed");
    // the cell's own bits join the incoming chain one cycle later
    a_or_chain_merge: assert property (!$past(srst_in) |-> rd_or_out ==
        ($past(rd_or_in) | ($past(rd_sel_in) ? {29'h0, $past(shift_out),
        $past(cell_b_out), $past(cell_a_out)} : 32'h0)))
        else $error("or-chain output wrong");
    a_chain_pass: assert property (!chain_en_in |-> chain_out == chain_in)
        else $error("mux chain did not pass through");
    a_sysrst_ack: assert property (!sys_rst_n_in |=> !wb_ack_out)
        else $error("ack during system reset");
    a_reset_clear: assert property ($fell(srst_in) |-> !wb_ack_out
        && rd_or_out == 32'h0 && wdata_route_out == 32'h0)
        else $error("outputs not cleared by power-on reset");

    c_write: cover property (wb_ack_out && wb_we_in);
    c_read: cover property (wb_ack_out && !wb_we_in);
    c_or_sel: cover property (rd_sel_in && rd_or_in != 32'h0);
    c_sysrst: cover property (!sys_rst_n_in ##1 sys_rst_n_in);
endmodule // plgc_cell_chk

bind plgc_cell plgc_cell_chk chk (.clk_in(clk_in), .srst_in(srst_in),
    .sys_rst_n_in(sys_rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .rd_or_in(rd_or_in), .rd_sel_in(rd_sel_in),
    .rd_or_out(rd_or_out), .cell_a_out(cell_a_out), .cell_b_out(cell_b_out),
    .shift_out(shift_out), .wdata_route_out(wdata_route_out), .chain_in(chain_in),
    .chain_en_in(chain_en_in), .chain_out(chain_out));

//--- tb/plgc_nbr.sv
// plgc_nbr.sv: neighbouring fabric feeding the or-chain, mux chain and carry
`timescale 1ns/10ps
module plgc_nbr (
    // clock and reset
    input  wire        clk_in,
    input  wire        srst_in,
    // random pattern from the bench
    input  wire [31:0] noise_in,
    // towards the cell
    output reg  [31:0] rd_or_out,
    output reg         rd_sel_out,
    output reg  [3:0]  chain_out,
    output reg         chain_en_out,
    output reg         carry_out
);
    always @(posedge clk_in) begin
        if (srst_in) begin
            rd_or_out    <= 32'h0;
            rd_sel_out   <= 1'b0;
            chain_out    <= 4'h0;
            chain_en_out <= 1'b0;
        end else begin
            // an upstream source that is not selected puts zero on the chain
            rd_or_out    <= noise_in[31] ? noise_in : 32'h0;
            rd_sel_out   <= noise_in[7];
            chain_out    <= noise_in[11:8];
            chain_en_out <= noise_in[12];
        end
        // random carry so cascade and arithmetic paths see both values
        carry_out <= noise_in[13];
    end
endmodule // plgc_nbr

//--- tb/test_programmable_logic_cell.sv
// test_programmable_logic_cell.sv: self-checking bench for the logic cell
`timescale 1ns/10ps
module test_programmable_logic_cell;
    reg         clk_in = 1'b0, srst_in = 1'b1, sys_rst_n = 1'b1, cfg_rst = 1'b0;
    reg         wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, in_e = 1'b0;
    reg  [7:0]  wb_adr = 8'h00;
    reg  [3:0]  wb_sel = 4'h0, in_a = 4'h0, in_b = 4'h0;
    reg  [31:0] wb_dat = 32'h0, nz = 32'd84230, seed = 32'd84230, q, t, lut;
    reg  [5:0]  gbuf = 6'h00;
    reg  [7:0]  sh;
    reg  [4:0]  a;
    reg  [2:0]  k;
    reg  [1:0]  sc;
    reg         ff_en = 1'b0, e_ff, f, ca;
    wire [31:0] wb_dat_out, rd_or, rd_or_out, wroute;
    wire [3:0]  chin, chout;
    wire        ack, cell_a, cell_b, shift_o, carry_o, rsel, chen, cin;
    integer     fail_count = 0, samples_checked = 0, cycles = 0, i, n;

    plgc_cell uut (.clk_in(clk_in), .srst_in(srst_in), .sys_rst_n_in(sys_rst_n),
        .cfg_reset_in(cfg_rst), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
        .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out),
        .wb_ack_out(ack), .in_a_in(in_a), .in_b_in(in_b), .in_e_in(in_e), .ff_en_in(ff_en),
        .gbuf_in(gbuf), .carry_in(cin), .cell_a_out(cell_a), .cell_b_out(cell_b),
        .shift_out(shift_o), .carry_out(carry_o), .wdata_route_out(wroute),
        .rd_or_in(rd_or), .rd_sel_in(rsel), .rd_or_out(rd_or_out), .chain_in(chin),
        .chain_en_in(chen), .chain_out(chout));
    plgc_nbr nbr (.clk_in(clk_in), .srst_in(srst_in), .noise_in(nz), .rd_or_out(rd_or),
        .rd_sel_out(rsel), .chain_out(chin), .chain_en_out(chen), .carry_out(cin));

    always #4 clk_in = ~clk_in;

    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction

    // one-bit step as {carry, sum}: add, subtract, add/subtract, multiply
    function [1:0] ar(input [1:0] op, input x, input y, input m, input c);
        reg q;
        begin
            q = (op == 2'h1 || (op == 2'h2 && m)) ? ~y : (op == 2'h3) ? x & m : y;
            ar = (op == 2'h3 ? y : x) + q + c;
        end
    endfunction

    task finish_test;
        begin
            if (fail_count == 0 && samples_checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    always @(posedge clk_in) begin
        nz <= xs(nz);
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            finish_test;
        end
    end

    task chk_word(input [63:0] name, input [31:0] e, input [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("BAD %0s exp %h got %h", name, e, g);
            end
        end
    endtask

    task chk_bit(input [63:0] name, input e, input g);
        chk_word(name, {31'h0, e}, {31'h0, g});
    endtask

    // one classic cycle; no latency assumed, the timeout ends a hang
    task wb(input [7:0] adr, input we, input [31:0] dat, input [3:0] sl);
        begin
            wb_cyc <= 1'b1;
            wb_stb <= 1'b1;
            wb_we  <= we;
            wb_adr <= adr;
            wb_sel <= sl;
            wb_dat <= dat;
            @(posedge clk_in);
            while (ack !== 1'b1) @(posedge clk_in);
            q = wb_dat_out;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
            wb_we  <= 1'b0;
            @(posedge clk_in);
        end
    endtask

    // the data differs across the two buffer edges, so the wrong polarity shows
    task tick(input dd, input we, input fall);
        begin
            in_b <= {2'b00, we, fall ? ~dd : dd};
            gbuf <= nz[5:0] | (6'h01 << k);
            repeat (2) @(posedge clk_in);
            in_b <= {2'b00, we & fall, fall ? dd : ~dd};
            repeat (2) @(posedge clk_in);
            gbuf <= nz[5:0] & ~(6'h01 << k);
            repeat (2) @(posedge clk_in);
            in_b <= 4'h0;
            @(posedge clk_in);
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        for (i = 0; i < 4; i = i + 1) begin
            wb(8'h00 + 8'h04 * i[1:0] + 8'h20 * (i / 3), 1'b0, 32'h0, 4'hf);
            chk_word("regrst", 32'h0, q);
        end
        seed = xs(seed);
        t = seed;
        wb(8'h04, 1'b1, t, 4'hf);
        seed = xs(seed);
        wb(8'h04, 1'b1, seed, 4'h5);
        t = {t[31:24], seed[23:16], t[15:8], seed[7:0]};
        wb(8'h04, 1'b0, 32'h0, 4'hf);
        chk_word("table", t, q);
        wb(8'h10, 1'b1, seed, 4'hf);
        wb(8'h10, 1'b0, 32'h0, 4'hf);
        chk_word("store", 32'h0, q);
        wb(8'h00, 1'b1, 32'h8000_0004, 4'hf);
        wb(8'h00, 1'b0, 32'h0, 4'hf);
        chk_word("ctrl", 32'h0000_0004, q);
        lut = t;
        for (i = 0; i < 16; i = i + 1) begin
            in_a <= i[3:0];
            @(negedge clk_in);
            chk_bit("ram16pre", lut[i], cell_a);
            @(posedge clk_in);
        end
        for (i = 0; i < 24; i = i + 1) begin
            seed = xs(seed);
            in_a <= seed[3:0];
            in_b <= {2'b00, seed[4], seed[5]};
            @(posedge clk_in);
            in_b <= 4'h0;
            if (seed[4])
                lut[seed[3:0]] = seed[5];
            @(negedge clk_in);
            chk_bit("ram16wr", lut[seed[3:0]], cell_a);
            @(posedge clk_in);
        end
        sys_rst_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        sys_rst_n <= 1'b1;
        @(posedge clk_in);
        wb(8'h10, 1'b0, 32'h0, 4'hf);
        chk_word("keep", lut, q);
        seed = xs(seed);
        k = seed[2:0] % 3'd6;
        t = xs(seed);
        seed = t;
        wb(8'h04, 1'b1, t, 4'hf);
        wb(8'h08, 1'b1, {29'h0, k}, 4'hf);
        // ram32, falling edge of picked buffer, load on write
        wb(8'h00, 1'b1, 32'h8000_001d, 4'hf);
        @(posedge clk_in);
        lut = t;
        for (i = 0; i < 12; i = i + 1) begin
            seed = xs(seed);
            a = seed[4:0];
            in_a <= a[3:0];
            in_e <= a[4];
            tick(seed[5], seed[6], 1'b1);
            if (seed[6])
                lut[a] = seed[5];
            @(negedge clk_in);
            chk_bit("ram32", lut[a], cell_a);
            @(posedge clk_in);
        end
        seed = xs(seed);
        sh = seed[31:24];
        wb(8'h08, 1'b1, {8'h00, sh, 13'h0, k}, 4'hf);
        wb(8'h00, 1'b1, 32'h0000_0016, 4'hf);
        cfg_rst <= 1'b1;
        @(posedge clk_in);
        cfg_rst <= 1'b0;
        @(posedge clk_in);
        @(negedge clk_in);
        chk_bit("shpre", sh[7], shift_o);
        @(posedge clk_in);
        for (i = 0; i < 12; i = i + 1) begin
            seed = xs(seed);
            tick(seed[0], 1'b0, 1'b0);
            sh = {sh[6:0], seed[0]};
            @(negedge clk_in);
            chk_bit("shift", sh[7], shift_o);
            @(posedge clk_in);
        end
        wb(8'h0c, 1'b0, 32'h0, 4'hf);
        chk_word("status", {24'h0, sh}, {24'h0, q[15:8]});
        // four/five-input tables, flip-flop, four arithmetic steps, wide xor
        for (n = 0; n < 7; n = n + 1) begin
            seed = xs(seed);
            t = seed;
            lut = (n == 0) ? 32'h0 : (n == 1) ? 32'h2041 : (n == 6) ? 32'h102 :
                  32'h3 + ((n - 2) << 11);
            wb(8'h04, 1'b1, t, 4'hf);
            // cascade passes, all four chains driven, load on write
            wb(8'h00, 1'b1, 32'h8003_c600 | lut, 4'hf);
            e_ff = (n == 1);
            for (i = 0; i < 10; i = i + 1) begin
                seed = xs(seed);
                a = {seed[8], seed[3:0]};
                in_a <= seed[3:0];
                in_b <= seed[7:4];
                in_e <= seed[8];
                ff_en <= seed[9];
                @(negedge clk_in);
                sc = ar(n[1:0] + 2'h2, seed[0], seed[1], seed[2], cin);
                f = (n == 1) ? t[a] : (n > 1 && n < 6) ? (seed[3] ? seed[4] : sc[0]) :
                    t[a[3:0]] ^ (n == 6 && seed[8] && t[{1'b1, seed[7:4]}]);
                ca = (n == 1) ? e_ff : f;
                chk_bit("cell_a", ca, cell_a);
                chk_bit("cell_b", n ? f : t[{1'b1, seed[7:4]}], cell_b);
                chk_bit("carry", (n > 1 && n < 6) ? sc[1] : f, carry_o);
                chk_word("chain", {28'h0, chen ? {4{ca}} : chin}, {28'h0, chout});
                @(posedge clk_in);
                if (seed[9])
                    e_ff = f;
            end
        end
        finish_test;
    end
endmodule // test_programmable_logic_cell
